// *** core/dsc_cfg.svh ***
// Constants of the diagnostic source configuration register bank.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH

// ==========================================================
// Register indices and bus decode
`define DSC_IDX_CELL_TEST     10'h06c
`define DSC_IDX_AUX_TEST      10'h06d
`define DSC_IDX_GEN_DIAG      10'h06e
`define DSC_IDX_LSB           2
`define DSC_IDX_MSB           11
`define DSC_ADDR_HI_LSB       12

// ==========================================================
// Field positions and counts
`define DSC_OW_SEL_BIT        15
`define DSC_CELL_MASK_MSB     14
`define DSC_AUX_MASK_MSB      5
`define DSC_AUX_MODE_MSB      15
`define DSC_AUX_MODE_LSB      13
`define DSC_NUM_CELLS         15
`define DSC_NUM_AUX           6
`define DSC_NUM_TWI_PINS      2

// ==========================================================
// Reset values
`define DSC_RST_CELL_TEST     16'h0000
`define DSC_RST_AUX_TEST      6'h00
`define DSC_RST_GEN_DIAG      3'h0

// ==========================================================
// Auxiliary diagnostic mode codes
`define DSC_MODE_NORMAL0      3'h0
`define DSC_MODE_NORMAL1      3'h1
`define DSC_MODE_DISCHARGE    3'h2
`define DSC_MODE_THERM_GND    3'h3

`endif

// *** core/dsc_pkg.sv ***
// Types shared by the diagnostic source configuration bank.
// Assumes dsc_cfg.svh is on the include path.
`include "dsc_cfg.svh"

package dsc_pkg;

  typedef logic [`DSC_NUM_CELLS-1:0] dsc_cell_vec_t;
  typedef logic [`DSC_NUM_AUX-1:0]   dsc_aux_vec_t;

  typedef enum logic [1:0] {
    DSC_SEL_NONE = 2'h0,
    DSC_SEL_CELL = 2'h1,
    DSC_SEL_AUX  = 2'h3,
    DSC_SEL_GEN  = 2'h2
  } dsc_reg_sel_t;

  typedef enum logic [2:0] {
    DSC_AUX_NORMAL0   = `DSC_MODE_NORMAL0,
    DSC_AUX_NORMAL1   = `DSC_MODE_NORMAL1,
    DSC_AUX_DISCHARGE = `DSC_MODE_DISCHARGE,
    DSC_AUX_THERM_GND = `DSC_MODE_THERM_GND
  } dsc_aux_mode_t;

endpackage

// *** core/dsc_aux_gate.sv ***
// Per-pin gating of auxiliary diagnostic sources and modes.
// Assumes pin role inputs are synchronous to the caller's clock; purely combinational.
`timescale 1ns/1ns
`default_nettype none
`include "dsc_cfg.svh"

module dsc_aux_gate (
  input  wire logic [`DSC_NUM_AUX-1:0] src_mask,
  input  wire logic [`DSC_NUM_AUX-1:0] digital_io_en,
  input  wire logic                    twi_en,
  input  wire logic [`DSC_NUM_AUX-1:0] ratiometric,
  input  wire logic [2:0]              mode,
  output logic      [`DSC_NUM_AUX-1:0] src_en,
  output logic      [`DSC_NUM_AUX-1:0] analog_pin,
  output logic      [`DSC_NUM_AUX-1:0] discharge_en,
  output logic                         therm_gnd
);

  genvar i;
  generate
    for (i = 0; i < `DSC_NUM_AUX; i = i + 1) begin : g_pin
      // Two-wire master borrows only the lowest pins
      if (i < `DSC_NUM_TWI_PINS) begin : g_twi
        assign analog_pin[i] = ~digital_io_en[i] & ~twi_en;
      end else begin : g_plain
        assign analog_pin[i] = ~digital_io_en[i];
      end
      assign src_en[i]       = src_mask[i] & analog_pin[i];
      // Discharge is meaningful only on ratiometric analog pins
      assign discharge_en[i] = (mode == `DSC_MODE_DISCHARGE) & analog_pin[i] & ratiometric[i];
    end
  endgenerate

  // Reserved codes 1xx fall through to no action
  assign therm_gnd = (mode == `DSC_MODE_THERM_GND) & (|analog_pin);

endmodule
`default_nettype wire

// *** core/dsc_diag_regs.sv ***
// Diagnostic source configuration registers with AHB-Lite slave port.
// Assumes a single 20 MHz hclk, async active-low hresetn, word-only transfers.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "dsc_cfg.svh"

module dsc_diag_regs (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic      [31:0]               hrdata,
  // Acquisition context
  input  wire logic [`DSC_NUM_CELLS-1:0] cell_measure_enable_mask,
  input  wire logic [`DSC_NUM_CELLS-1:0] cell_polarity,
  input  wire logic [`DSC_NUM_AUX-1:0]   aux_pin_digital_io_enable,
  input  wire logic                      two_wire_master_enable,
  input  wire logic [`DSC_NUM_AUX-1:0]   aux_ratiometric,
  // Analog and sequencer controls
  output logic                           cell_open_wire_mode_sel,
  output logic      [`DSC_NUM_CELLS-1:0] cell_measure_sel,
  output logic      [`DSC_NUM_CELLS-1:0] cell_diag_source_en,
  output logic                           adc_check_en,
  output logic                           comp_high_side_en,
  output logic                           comp_low_side_en,
  output logic                           open_wire_threshold_sel,
  output logic      [`DSC_NUM_AUX-1:0]   aux_diag_source_en,
  output logic      [`DSC_NUM_AUX-1:0]   aux_accel_discharge_en,
  output logic                           thermistor_bias_to_ground
);

  // ==========================================================
  // Address decode
  function automatic dsc_pkg::dsc_reg_sel_t reg_decode(input logic [31:0] addr);
    dsc_pkg::dsc_reg_sel_t sel;
    sel = dsc_pkg::DSC_SEL_NONE;
    if (addr[31:`DSC_ADDR_HI_LSB] == '0) begin
      case (addr[`DSC_IDX_MSB:`DSC_IDX_LSB])
        `DSC_IDX_CELL_TEST: sel = dsc_pkg::DSC_SEL_CELL;
        `DSC_IDX_AUX_TEST:  sel = dsc_pkg::DSC_SEL_AUX;
        `DSC_IDX_GEN_DIAG:  sel = dsc_pkg::DSC_SEL_GEN;
        default:            sel = dsc_pkg::DSC_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  logic                  addr_phase;
  dsc_pkg::dsc_reg_sel_t rd_sel;
  logic                  wr_pend_r;
  dsc_pkg::dsc_reg_sel_t wr_sel_r;
  logic [15:0]           cell_test_r;
  logic [15:0]           cell_test_nxt;
  logic [`DSC_NUM_AUX-1:0] aux_test_r;
  logic [`DSC_NUM_AUX-1:0] aux_test_nxt;
  logic [2:0]            gen_mode_r;
  logic [2:0]            gen_mode_nxt;
  logic [31:0]           hrdata_r;
  logic [31:0]           hrdata_nxt;

  // Zero wait states; every transfer answers OKAY
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel & htrans[1] & hready;
  assign rd_sel     = reg_decode(haddr);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_sel_r  <= dsc_pkg::DSC_SEL_NONE;
    end else if (hready) begin
      wr_pend_r <= addr_phase & hwrite;
      wr_sel_r  <= reg_decode(haddr);
    end
  end

  // ==========================================================
  // Register storage
  always_comb begin
    cell_test_nxt = cell_test_r;
    aux_test_nxt  = aux_test_r;
    gen_mode_nxt  = gen_mode_r;
    if (wr_pend_r) begin
      case (wr_sel_r)
        dsc_pkg::DSC_SEL_CELL: cell_test_nxt = hwdata[15:0];
        dsc_pkg::DSC_SEL_AUX:  aux_test_nxt  = hwdata[`DSC_AUX_MASK_MSB:0];
        dsc_pkg::DSC_SEL_GEN:  gen_mode_nxt  = hwdata[`DSC_AUX_MODE_MSB:`DSC_AUX_MODE_LSB];
        default:               cell_test_nxt = cell_test_r;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cell_test_r <= `DSC_RST_CELL_TEST;
      aux_test_r  <= `DSC_RST_AUX_TEST;
      gen_mode_r  <= `DSC_RST_GEN_DIAG;
    end else begin
      cell_test_r <= cell_test_nxt;
      aux_test_r  <= aux_test_nxt;
      gen_mode_r  <= gen_mode_nxt;
    end
  end

  // ==========================================================
  // Read path
  // Reads from the next values so a write just ahead is never missed
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    case (rd_sel)
      dsc_pkg::DSC_SEL_CELL: hrdata_nxt[15:0] = cell_test_nxt;
      // Raw written mask, not the gated one
      dsc_pkg::DSC_SEL_AUX:  hrdata_nxt[`DSC_AUX_MASK_MSB:0] = aux_test_nxt;
      dsc_pkg::DSC_SEL_GEN:  hrdata_nxt[`DSC_AUX_MODE_MSB:`DSC_AUX_MODE_LSB] = gen_mode_nxt;
      default:               hrdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata_r <= hrdata_nxt;
    end
  end

  assign hrdata = hrdata_r;

  // ==========================================================
  // Cell channel selection
  logic                      ow_mode;
  logic [`DSC_NUM_CELLS-1:0] meas_sel_nxt;

  assign ow_mode = cell_test_r[`DSC_OW_SEL_BIT];

  genvar c;
  generate
    for (c = 0; c < `DSC_NUM_CELLS; c = c + 1) begin : g_cell
      assign meas_sel_nxt[c] = ow_mode ? (cell_measure_enable_mask[c] & ~cell_polarity[c])
                                       : cell_measure_enable_mask[c];
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cell_open_wire_mode_sel <= 1'b0;
      cell_measure_sel        <= '0;
      cell_diag_source_en     <= '0;
      adc_check_en            <= 1'b1;
      comp_high_side_en       <= 1'b1;
      comp_low_side_en        <= 1'b1;
      open_wire_threshold_sel <= 1'b0;
    end else begin
      cell_open_wire_mode_sel <= ow_mode;
      cell_measure_sel        <= meas_sel_nxt;
      cell_diag_source_en     <= cell_test_r[`DSC_CELL_MASK_MSB:0];
      // Open-wire restricts checks to the low-side comparator
      adc_check_en            <= ~ow_mode;
      comp_high_side_en       <= ~ow_mode;
      comp_low_side_en        <= 1'b1;
      open_wire_threshold_sel <= ow_mode;
    end
  end

  // ==========================================================
  // Auxiliary inputs
  logic [`DSC_NUM_AUX-1:0] aux_src_comb;
  logic [`DSC_NUM_AUX-1:0] aux_analog;
  logic [`DSC_NUM_AUX-1:0] aux_dis_comb;
  logic                    therm_gnd_comb;

  dsc_aux_gate u_aux_gate (
    .src_mask      (aux_test_r),
    .digital_io_en (aux_pin_digital_io_enable),
    .twi_en        (two_wire_master_enable),
    .ratiometric   (aux_ratiometric),
    .mode          (gen_mode_r),
    .src_en        (aux_src_comb),
    .analog_pin    (aux_analog),
    .discharge_en  (aux_dis_comb),
    .therm_gnd     (therm_gnd_comb)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux_diag_source_en        <= '0;
      aux_accel_discharge_en    <= '0;
      thermistor_bias_to_ground <= 1'b0;
    end else begin
      aux_diag_source_en        <= aux_src_comb;
      aux_accel_discharge_en    <= aux_dis_comb;
      thermistor_bias_to_ground <= therm_gnd_comb;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence cell_wr_s;
    addr_phase && hwrite && (reg_decode(haddr) == dsc_pkg::DSC_SEL_CELL);
  endsequence

  sequence aux_rd_s;
    addr_phase && !hwrite && (reg_decode(haddr) == dsc_pkg::DSC_SEL_AUX);
  endsequence

  // Outputs trail the register by one more edge than the write data phase
  property cell_wr_lands_p;
    cell_wr_s ##2 1'b1 |=> cell_open_wire_mode_sel == $past(hwdata[`DSC_OW_SEL_BIT], 2);
  endproperty

  ow_mode_write_a: assert property (cell_wr_lands_p)
    else $error("open-wire mode output does not follow written bit");

  // Skip the release edge, where the output flops still take their reset branch
  normal_select_a: assert property (hresetn && !ow_mode |=>
    (cell_measure_sel == $past(cell_measure_enable_mask)) && adc_check_en && comp_high_side_en)
    else $error("normal mode selection or checks wrong");

  ow_select_a: assert property (ow_mode |=>
    cell_measure_sel == ($past(cell_measure_enable_mask) & ~$past(cell_polarity)))
    else $error("open-wire selection ignores polarity");

  lowside_only_a: assert property (cell_open_wire_mode_sel |->
    !adc_check_en && !comp_high_side_en && comp_low_side_en && open_wire_threshold_sel)
    else $error("open-wire mode runs checks other than low-side");

  cell_source_a: assert property (cell_wr_s ##2 1'b1 |=>
    cell_diag_source_en == $past(hwdata[`DSC_CELL_MASK_MSB:0], 2))
    else $error("cell source enables do not follow written mask");

  aux_source_a: assert property ((1'b1) |=>
    aux_diag_source_en == ($past(aux_test_r) & ~$past(aux_pin_digital_io_enable)
      & ~{{(`DSC_NUM_AUX-`DSC_NUM_TWI_PINS){1'b0}}, {`DSC_NUM_TWI_PINS{$past(two_wire_master_enable)}}}))
    else $error("aux source enables wrong");

  aux_readback_a: assert property (aux_rd_s ##1 !wr_pend_r |->
    hrdata == {26'h0, aux_test_r})
    else $error("aux readback is not the written value");

  twi_mask_a: assert property (two_wire_master_enable |=>
    aux_diag_source_en[`DSC_NUM_TWI_PINS-1:0] == '0)
    else $error("two-wire mode leaves low aux sources on");

  therm_mode_a: assert property ((gen_mode_r == `DSC_MODE_THERM_GND) && (|aux_analog) |=>
    thermistor_bias_to_ground && (aux_accel_discharge_en == '0))
    else $error("thermistor grounding mode not applied");

  untested_pin_a: assert property ((1'b1) |=>
    (aux_accel_discharge_en & $past(aux_pin_digital_io_enable)) == '0)
    else $error("discharge applied to a non-analog pin");

  reserved_zero_a: assert property (aux_rd_s |=> hrdata[31:`DSC_AUX_MASK_MSB+1] == '0)
    else $error("unused aux bits read nonzero");

  sequence cell_rd_s;
    addr_phase && !hwrite && (reg_decode(haddr) == dsc_pkg::DSC_SEL_CELL);
  endsequence

  sequence gen_rd_s;
    addr_phase && !hwrite && (reg_decode(haddr) == dsc_pkg::DSC_SEL_GEN);
  endsequence

  sequence aux_wr_s;
    addr_phase && hwrite && (reg_decode(haddr) == dsc_pkg::DSC_SEL_AUX);
  endsequence

  sequence gen_wr_s;
    addr_phase && hwrite && (reg_decode(haddr) == dsc_pkg::DSC_SEL_GEN);
  endsequence

  // Pins lent to another role, rebuilt from the role inputs rather than the gate
  logic [`DSC_NUM_AUX-1:0] role_busy;

  assign role_busy = aux_pin_digital_io_enable
    | {{(`DSC_NUM_AUX-`DSC_NUM_TWI_PINS){1'b0}}, {`DSC_NUM_TWI_PINS{two_wire_master_enable}}};

  reset_value_a: assert property ($rose(hresetn) |->
    (cell_test_r == `DSC_RST_CELL_TEST) && (aux_test_r == `DSC_RST_AUX_TEST) && (gen_mode_r == `DSC_RST_GEN_DIAG))
    else $error("register not cleared by reset");

  unmapped_write_a: assert property (wr_pend_r && (wr_sel_r == dsc_pkg::DSC_SEL_NONE) |=>
    $stable(cell_test_r) && $stable(aux_test_r) && $stable(gen_mode_r))
    else $error("write to an unmapped address changed a register");

  cell_readback_a: assert property (cell_rd_s |=> hrdata == {16'h0000, cell_test_r})
    else $error("cell register readback wrong");

  gen_readback_a: assert property (gen_rd_s |=>
    hrdata == {16'h0000, gen_mode_r, 13'h0000})
    else $error("mode register readback wrong");

  aux_mask_write_a: assert property (aux_wr_s ##1 1'b1 |=>
    aux_test_r == $past(hwdata[`DSC_AUX_MASK_MSB:0]))
    else $error("aux mask write did not land");

  mode_write_a: assert property (gen_wr_s ##1 1'b1 |=>
    gen_mode_r == $past(hwdata[`DSC_AUX_MODE_MSB:`DSC_AUX_MODE_LSB]))
    else $error("aux mode write did not land");

  discharge_mode_a: assert property ((gen_mode_r == `DSC_MODE_DISCHARGE) |=>
    aux_accel_discharge_en == (~$past(role_busy) & $past(aux_ratiometric)))
    else $error("discharge not applied to ratiometric analog pins");

  normal_quiet_a: assert property ((gen_mode_r[2:1] == 2'b00) |=>
    !thermistor_bias_to_ground && (aux_accel_discharge_en == '0))
    else $error("normal aux mode drives a diagnostic");

  normal_checks_a: assert property (!cell_open_wire_mode_sel |->
    adc_check_en && comp_high_side_en && comp_low_side_en && !open_wire_threshold_sel)
    else $error("normal mode checks or thresholds wrong");

  twi_high_pins_a: assert property (two_wire_master_enable |=>
    aux_diag_source_en[`DSC_AUX_MASK_MSB:`DSC_NUM_TWI_PINS]
      == ($past(aux_test_r[`DSC_AUX_MASK_MSB:`DSC_NUM_TWI_PINS])
      & ~$past(role_busy[`DSC_AUX_MASK_MSB:`DSC_NUM_TWI_PINS])))
    else $error("two-wire mode masks high aux sources");

endmodule
`default_nettype wire

// *** dv/test_diag_source_config_regs.sv ***
// Self-checking bench for the diagnostic source configuration register bank.
// Assumes dsc_cfg.svh on the include path; the bench is the only AHB-Lite master.
`timescale 1ns/1ns
`default_nettype none
`include "dsc_cfg.svh"

module test_diag_source_config_regs;
  // ==========================================================
  // Signals
  logic                      hclk;
  logic                      hresetn;
  logic                      hsel;
  logic [31:0]               haddr;
  logic [1:0]                htrans;
  logic                      hwrite;
  logic [2:0]                hsize;
  logic [31:0]               hwdata;
  wire logic                 hready;
  logic                      hreadyout;
  logic                      hresp;
  logic [31:0]               hrdata;
  logic [`DSC_NUM_CELLS-1:0] cem;
  logic [`DSC_NUM_CELLS-1:0] pol;
  logic [`DSC_NUM_AUX-1:0]   dio;
  logic                      twi;
  logic [`DSC_NUM_AUX-1:0]   rat;
  logic                      ow_sel;
  logic [`DSC_NUM_CELLS-1:0] meas_sel;
  logic [`DSC_NUM_CELLS-1:0] cell_src;
  logic                      adc_en;
  logic                      hi_en;
  logic                      lo_en;
  logic                      thr_sel;
  logic [`DSC_NUM_AUX-1:0]   aux_src;
  logic [`DSC_NUM_AUX-1:0]   dis_en;
  logic                      therm;
  int                        bad_count;
  int                        comparisons;
  int                        cyc;
  int                        m_cell;
  int                        m_aux;
  int                        m_mode;
  logic [31:0]               d;
  logic [31:0]               amap [3];

  localparam logic [31:0] A_CELL = {20'h0, `DSC_IDX_CELL_TEST, 2'b00};
  localparam logic [31:0] A_AUX  = {20'h0, `DSC_IDX_AUX_TEST, 2'b00};
  localparam logic [31:0] A_GEN  = {20'h0, `DSC_IDX_GEN_DIAG, 2'b00};

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  dsc_diag_regs i_dsc_diag_regs (
    .hclk                      (hclk),
    .hresetn                   (hresetn),
    .hsel                      (hsel),
    .haddr                     (haddr),
    .htrans                    (htrans),
    .hwrite                    (hwrite),
    .hsize                     (hsize),
    .hwdata                    (hwdata),
    .hready                    (hready),
    .hreadyout                 (hreadyout),
    .hresp                     (hresp),
    .hrdata                    (hrdata),
    .cell_measure_enable_mask  (cem),
    .cell_polarity             (pol),
    .aux_pin_digital_io_enable (dio),
    .two_wire_master_enable    (twi),
    .aux_ratiometric           (rat),
    .cell_open_wire_mode_sel   (ow_sel),
    .cell_measure_sel          (meas_sel),
    .cell_diag_source_en       (cell_src),
    .adc_check_en              (adc_en),
    .comp_high_side_en         (hi_en),
    .comp_low_side_en          (lo_en),
    .open_wire_threshold_sel   (thr_sel),
    .aux_diag_source_en        (aux_src),
    .aux_accel_discharge_en    (dis_en),
    .thermistor_bias_to_ground (therm)
  );

  // ==========================================================
  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      final_report();
    end
  end

  // ==========================================================
  // Checking and bus tasks
  task automatic final_report();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address phase held until ready, then data phase held until ready
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (wr)
      hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, a, wd, rd);
    if (a == A_CELL)
      m_cell = int'(wd[15:0]);
    else if (a == A_AUX)
      m_aux = int'(wd[5:0]);
    else if (a == A_GEN)
      m_mode = int'(wd[15:13]);
  endtask

  task automatic rd_chk(input logic [31:0] a);
    logic [31:0] rd;
    int          e;
    bus(1'b0, a, 32'h0, rd);
    e = (a == A_CELL) ? m_cell : (a == A_AUX) ? m_aux : (a == A_GEN) ? (m_mode << 13) : 0;
    chk(rd, 32'(e));
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Outputs lag the register write by one edge; two edges leave margin
  task automatic out_chk();
    int ow;
    int an;
    repeat (2) @(posedge hclk);
    #1;
    ow = (m_cell >> 15) & 1;
    an = ~int'(dio) & 'h3f;
    if (twi)
      an = an & 'h3c;
    chk(ow_sel, ow);
    chk(meas_sel, ow ? (cem & ~pol) : cem);
    chk({adc_en, hi_en, lo_en, thr_sel}, ow ? 4'h3 : 4'he);
    chk(cell_src, m_cell & 'h7fff);
    chk(aux_src, m_aux & an);
    chk(dis_en, (m_mode == 2) ? (an & int'(rat)) : 0);
    chk(therm, (m_mode == 3) && (an != 0));
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    bad_count = 0;
    comparisons = 0;
    cyc = 0;
    m_cell = 0;
    m_aux = 0;
    m_mode = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cem = '0;
    pol = '0;
    dio = '0;
    twi = 1'b0;
    rat = '0;
    amap = '{A_CELL, A_AUX, A_GEN};
    void'($urandom(12603));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int k = 0; k < 3; k++)
      rd_chk(amap[k]);
    out_chk();
    for (int i = 0; i < 48; i++) begin
      @(posedge hclk);
      cem <= 15'($urandom);
      pol <= 15'($urandom);
      dio <= 6'($urandom) & 6'($urandom);
      twi <= 1'($urandom);
      rat <= 6'($urandom);
      d = $urandom;
      if (i % 3 == 2)
        d[15:13] = {1'b0, 2'(i / 3)};
      wr(amap[i % 3], d);
      rd_chk(amap[i % 3]);
      out_chk();
    end
    // Unmapped neighbours and a high-address alias must stay inert
    wr(A_GEN + 32'h4, 32'hffff_ffff);
    wr(A_CELL - 32'h4, 32'hffff_ffff);
    wr(A_CELL | 32'h0000_1000, 32'hffff_ffff);
    rd_chk(A_GEN + 32'h4);
    rd_chk(A_CELL | 32'h0000_1000);
    for (int k = 0; k < 3; k++)
      rd_chk(amap[k]);
    // Open-wire mode paired with discharge, every pin analog
    @(posedge hclk);
    dio <= '0;
    twi <= 1'b0;
    rat <= 6'h3f;
    wr(A_CELL, 32'h0000_ffff);
    wr(A_GEN, 32'h0000_4000);
    out_chk();
    // Reset in mid-run clears every field
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    m_cell = 0;
    m_aux = 0;
    m_mode = 0;
    for (int k = 0; k < 3; k++)
      rd_chk(amap[k]);
    out_chk();
    final_report();
  end
endmodule
`default_nettype wire
